// ===== design/servo_input_regs.vh
// register offsets, field positions, reset values and timing counts of the input block
`ifndef SERVO_INPUT_REGS_VH
`define SERVO_INPUT_REGS_VH
// ==========================================================
// register offsets (byte addresses, word aligned)
`define REG_CTRL        8'h00
`define REG_DIGIN       8'h04
`define REG_ALARM       8'h08
`define REG_IRQ_STATUS  8'h0c
`define REG_IRQ_MASK    8'h10
`define REG_SPEED_LIMIT 8'h14
`define REG_TORQUE_CMD  8'h18
`define REG_HIST_INDEX  8'h1c
`define REG_HIST_DATA   8'h20
`define REG_ALLOC       8'h24
// ==========================================================
// control register fields
`define CTRL_OT_LO      0
`define CTRL_OT_HI      1
`define CTRL_HOMING     2
`define CTRL_TORQUE     3
`define CTRL_SPDSRC     4
`define CTRL_SWCLR      5
`define CTRL_RESET      32'h0000_0000
// ==========================================================
// digital input object bit positions
`define DI_NEG_OT       0
`define DI_POS_OT       1
`define DI_HOME         2
`define DI_LATCH1       3
`define DI_LATCH2       4
`define DI_FORCED       5
`define DI_MON_LO       6
// ==========================================================
// alarm codes: main 8 bits, sub 4 bits
`define ALARM_NONE      12'h000
`define ALARM_FORCED    12'h570
`define ALARM_OT        12'h380
`define ALARM_UNCLEAR   12'h500
// ==========================================================
// interrupt status bits
`define IRQ_ALARM       0
`define IRQ_LATCH1      1
`define IRQ_LATCH2      2
`define IRQ_OT          3
`define IRQ_HOME        4
// ==========================================================
// input slot allocation reset values
`define SLOT_LATCH1     4'h5
`define SLOT_LATCH2     4'h6
`define ALLOC_RESET     8'h65
// ==========================================================
// timing
`define CLK_PERIOD_NS   10
`define FILTER_NS       100
`define FILTER_CYC      ((`FILTER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define LATCH_MIN_MS    2
`define LATCH_MIN_CYC   ((`LATCH_MIN_MS * 1000000) / `CLK_PERIOD_NS)
`define SPEED_LIMIT_RST 16'h0bb8
`endif

// ===== design/servo_input_handler.v
// input signal handling for the servo drive i/o connector
//
// The implementer's own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
// Functional notes
// [RULE1] forced-alarm input raises alarm 87.0
// [RULE2] travel inhibits apply over-travel setup response
// [RULE3] near-home input used as home during homing
// [RULE4] latch inputs are active-closed contacts for capture
// [RULE5] source holds latch closed 2 ms minimum
// [RULE6] latch one only slot 5, two slot 6
// [RULE7] monitor inputs only reported in digital inputs
// [RULE8] alarm clear clears except non-clearable alarms
// [RULE9] torque command only from fieldbus in torque mode
// [RULE10] torque mode speed limit from parameter or fieldbus
// [RULE11] alarm history kept for later read back
// [RULE12] inputs synchronised and deglitched before use
`include "servo_input_regs.vh"
// ==========================================================
// register map overview
// ctrl (rw):
//   [1:0] over-travel response
//         0: per-direction inhibit
//         1: inhibit inputs ignored
//         2: stop and raise an alarm
//         3: no response
//   [2]   homing sequence active
//   [3]   torque mode, command from the bus port
//   [4]   speed limit taken from the bus port
//   [5]   write one for a software alarm clear, reads zero
// digin (ro): filtered pin levels, monitor inputs on top
// alarm (ro): current alarm code, main and sub number
// irq status (w1c) and irq mask (rw):
//   [0] alarm raised
//   [1] latch one captured
//   [2] latch two captured
//   [3] travel inhibit switched on
//   [4] home edge seen while homing
// speed limit (rw) and torque command (rw): stored values
// hist index: write selects the age, read gives the pointer
// hist data (ro): code of the selected history entry
// alloc (rw): slot numbers of both latch inputs
// ==========================================================
// hazards and limits
// - every pin path is two flops plus the stable counter,
//   so a pin change shows up about a dozen cycles later
// - a raise and a clear in one cycle: the raise wins, so
//   a fresh fault is never lost behind a late clear
// - a status event and its clear in one cycle: the event
//   wins, software sees it on the next read
// - the history ring overwrites its oldest entry when full
// - latch pulses count only while the slot setting is the
//   fixed one, any other value silences the capture
// - read data stand one cycle after the strobe, zero else
module servo_input_handler #(
  parameter NUM_MON    = 5,
  parameter HIST_DEPTH = 8,
  parameter LATCH_CYC  = `LATCH_MIN_CYC
) (
  input  wire                clk_i,
  input  wire                rstn_i,
  input  wire                forced_alarm_i,
  input  wire                positive_travel_inhibit_i,
  input  wire                negative_travel_inhibit_i,
  input  wire                near_home_i,
  input  wire                latch_input_one_i,
  input  wire                latch_input_two_i,
  input  wire [NUM_MON-1:0]  general_monitor_input_i,
  input  wire                alarm_clear_input_i,
  input  wire [15:0]         fieldbus_torque_i,
  input  wire [15:0]         fieldbus_speed_limit_i,
  input  wire [7:0]          addr_i,
  input  wire [31:0]         wdata_i,
  input  wire                wr_i,
  input  wire                rd_i,
  output reg  [31:0]         rdata_o,
  output reg                 irq_o,
  output reg                 alarm_o,
  output reg                 inhibit_pos_o,
  output reg                 inhibit_neg_o,
  output reg                 inhibit_stop_o,
  output reg                 home_sensor_o,
  output reg                 probe_one_o,
  output reg                 probe_two_o,
  output reg  [15:0]         torque_cmd_o,
  output reg  [15:0]         speed_limit_o
);
  localparam NIN = 7 + NUM_MON;
  localparam FW  = 4;
  localparam HW  = 3;
  localparam LW  = 24;

  // ==========================================================
  // input sampling and glitch filter
  wire [NIN-1:0] raw_in = {general_monitor_input_i, alarm_clear_input_i, forced_alarm_i,
                           latch_input_two_i, latch_input_one_i, near_home_i,
                           positive_travel_inhibit_i, negative_travel_inhibit_i};
  wire [NIN-1:0] clean;

  genvar g;
  generate
    for (g = 0; g < NIN; g = g + 1) begin : g_in
      reg          s1;
      reg          s2;
      reg [FW-1:0] cnt;
      reg          q;
      // two-stage sync then stable-count filter, see [RULE12]
      always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          s1  <= 1'b0;
          s2  <= 1'b0;
          cnt <= {FW{1'b0}};
          q   <= 1'b0;
        end else begin
          s1 <= raw_in[g];
          s2 <= s1;
          if (s2 == q) begin
            cnt <= {FW{1'b0}};
          end else if (cnt == `FILTER_CYC - 1) begin
            q   <= s2;
            cnt <= {FW{1'b0}};
          end else begin
            cnt <= cnt + 1'b1;
          end
        end
      end
      assign clean[g] = q;
    end
  endgenerate

  wire          neg_ot  = clean[0];
  wire          pos_ot  = clean[1];
  wire          home_in = clean[2];
  wire          lat1_in = clean[3];
  wire          lat2_in = clean[4];
  wire          forced  = clean[5];
  wire          aclr    = clean[6];
  wire [NUM_MON-1:0] mon = clean[NIN-1:7];

  // ==========================================================
  // software registers
  reg  [31:0] ctrl;
  reg  [4:0]  irq_status;
  reg  [4:0]  irq_mask;
  reg  [15:0] speed_param;
  reg  [15:0] torque_fb;
  reg  [HW-1:0] hist_index;
  reg  [7:0]  alloc;
  reg  [11:0] alarm_code;
  reg  [11:0] hist [0:HIST_DEPTH-1];
  reg  [HW-1:0] hist_wp;
  reg         forced_d;
  reg         aclr_d;
  reg         lat1_d;
  reg         lat2_d;
  reg         home_d;
  reg         ot_d;
  reg  [LW-1:0] lat1_cnt;
  reg  [LW-1:0] lat2_cnt;
  reg         lat1_fired;
  reg         lat2_fired;

  wire wr_ctrl  = wr_i && (addr_i == `REG_CTRL);
  wire wr_stat  = wr_i && (addr_i == `REG_IRQ_STATUS);
  wire wr_mask  = wr_i && (addr_i == `REG_IRQ_MASK);
  wire wr_spd   = wr_i && (addr_i == `REG_SPEED_LIMIT);
  wire wr_trq   = wr_i && (addr_i == `REG_TORQUE_CMD);
  wire wr_hidx  = wr_i && (addr_i == `REG_HIST_INDEX);
  wire wr_alloc = wr_i && (addr_i == `REG_ALLOC);

  // latch inputs only valid on their fixed slots
  wire lat1_ok = (alloc[3:0] == `SLOT_LATCH1); // see [RULE6]
  wire lat2_ok = (alloc[7:4] == `SLOT_LATCH2); // see [RULE6]

  // alarm raise and clear decisions
  wire forced_rise = forced && !forced_d;
  wire clear_req   = (aclr && !aclr_d) || (wr_ctrl && wdata_i[`CTRL_SWCLR]);
  wire clearable   = (alarm_code != `ALARM_UNCLEAR);
  wire ot_on       = pos_ot || neg_ot;
  wire [1:0] ot_mode = ctrl[`CTRL_OT_HI:`CTRL_OT_LO];
  wire ot_alarm    = ot_on && !ot_d && (ot_mode == 2'd2);
  wire raise       = forced_rise || ot_alarm;
  wire [11:0] next_code = forced_rise ? `ALARM_FORCED : `ALARM_OT;

  // closed-time qualified latch events, active when closed
  wire lat1_hit = lat1_in && lat1_ok && !lat1_fired && (lat1_cnt == LATCH_CYC - 1); // see [RULE4]
  wire lat2_hit = lat2_in && lat2_ok && !lat2_fired && (lat2_cnt == LATCH_CYC - 1); // see [RULE4]
  wire home_ev  = home_in && !home_d && ctrl[`CTRL_HOMING];
  wire [4:0] events = {home_ev, ot_on && !ot_d, lat2_hit, lat1_hit, raise};

  // register writes, alarm latch and history
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ctrl        <= `CTRL_RESET;
      irq_status  <= 5'h00;
      irq_mask    <= 5'h00;
      speed_param <= `SPEED_LIMIT_RST;
      torque_fb   <= 16'h0000;
      hist_index  <= {HW{1'b0}};
      alloc       <= `ALLOC_RESET;
      alarm_code  <= `ALARM_NONE;
      hist_wp     <= {HW{1'b0}};
      forced_d    <= 1'b0;
      aclr_d      <= 1'b0;
      home_d      <= 1'b0;
      ot_d        <= 1'b0;
    end else begin
      forced_d <= forced;
      aclr_d   <= aclr;
      home_d   <= home_in;
      ot_d     <= ot_on;
      if (wr_ctrl) begin
        ctrl <= {26'h0, 1'b0, wdata_i[4:0]};
      end
      if (wr_mask) begin
        irq_mask <= wdata_i[4:0];
      end
      if (wr_spd) begin
        speed_param <= wdata_i[15:0];
      end
      if (wr_trq) begin
        torque_fb <= wdata_i[15:0];
      end
      if (wr_hidx) begin
        hist_index <= wdata_i[HW-1:0];
      end
      if (wr_alloc) begin
        alloc <= wdata_i[7:0];
      end
      // write-one-to-clear, new events win
      irq_status <= (irq_status & ~(wr_stat ? wdata_i[4:0] : 5'h00)) | events;
      if (raise) begin
        alarm_code    <= next_code; // see [RULE1]
        hist[hist_wp] <= next_code; // see [RULE11]
        hist_wp       <= hist_wp + 1'b1;
      end else if (clear_req && clearable) begin
        alarm_code <= `ALARM_NONE; // see [RULE8]
      end
    end
  end

  // latch closed-time counters
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      lat1_cnt   <= {LW{1'b0}};
      lat2_cnt   <= {LW{1'b0}};
      lat1_fired <= 1'b0;
      lat2_fired <= 1'b0;
      lat1_d     <= 1'b0;
      lat2_d     <= 1'b0;
    end else begin
      lat1_d <= lat1_in;
      lat2_d <= lat2_in;
      // pulse shorter than the minimum is ignored, see [RULE5]
      lat1_cnt   <= lat1_in ? (lat1_cnt == LATCH_CYC - 1 ? lat1_cnt : lat1_cnt + 1'b1) : {LW{1'b0}};
      lat2_cnt   <= lat2_in ? (lat2_cnt == LATCH_CYC - 1 ? lat2_cnt : lat2_cnt + 1'b1) : {LW{1'b0}};
      lat1_fired <= lat1_in && (lat1_fired || lat1_hit);
      lat2_fired <= lat2_in && (lat2_fired || lat2_hit);
    end
  end

  // drive-facing outputs and read port
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_o        <= 32'h0000_0000;
      irq_o          <= 1'b0;
      alarm_o        <= 1'b0;
      inhibit_pos_o  <= 1'b0;
      inhibit_neg_o  <= 1'b0;
      inhibit_stop_o <= 1'b0;
      home_sensor_o  <= 1'b0;
      probe_one_o    <= 1'b0;
      probe_two_o    <= 1'b0;
      torque_cmd_o   <= 16'h0000;
      speed_limit_o  <= 16'h0000;
    end else begin
      irq_o         <= |(irq_status & irq_mask);
      alarm_o       <= (alarm_code != `ALARM_NONE);
      // mode 0: per-direction inhibit, 1: disabled, 2: alarm
      inhibit_pos_o <= pos_ot && (ot_mode == 2'd0); // see [RULE2]
      inhibit_neg_o <= neg_ot && (ot_mode == 2'd0); // see [RULE2]
      inhibit_stop_o <= ot_on && (ot_mode == 2'd2); // see [RULE2]
      home_sensor_o <= home_in && ctrl[`CTRL_HOMING]; // see [RULE3]
      probe_one_o   <= lat1_hit;
      probe_two_o   <= lat2_hit;
      // torque from fieldbus in torque mode, else the stored register, see [RULE9]
      torque_cmd_o  <= ctrl[`CTRL_TORQUE] ? fieldbus_torque_i : torque_fb;
      // speed limit source select, see [RULE10]
      speed_limit_o <= ctrl[`CTRL_SPDSRC] ? fieldbus_speed_limit_i : speed_param;
      rdata_o <= 32'h0000_0000;
      if (rd_i) begin
        case (addr_i)
          `REG_CTRL:        rdata_o <= ctrl;
          // monitor inputs only reach this object, see [RULE7]
          `REG_DIGIN:       rdata_o <= {{(26-NUM_MON){1'b0}}, mon, forced, lat2_in, lat1_in,
                                        home_in, pos_ot, neg_ot};
          `REG_ALARM:       rdata_o <= {20'h0, alarm_code};
          `REG_IRQ_STATUS:  rdata_o <= {27'h0, irq_status};
          `REG_IRQ_MASK:    rdata_o <= {27'h0, irq_mask};
          `REG_SPEED_LIMIT: rdata_o <= {16'h0, speed_param};
          `REG_TORQUE_CMD:  rdata_o <= {16'h0, torque_fb};
          `REG_HIST_INDEX:  rdata_o <= {29'h0, hist_wp};
          `REG_HIST_DATA:   rdata_o <= {20'h0, hist[hist_wp - 1'b1 - hist_index]}; // see [RULE11]
          `REG_ALLOC:       rdata_o <= {24'h0, alloc};
          default:          rdata_o <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule

// ===== tb/servo_input_chk_asserts.sv
// port assertions for the input handler
`timescale 1ns/1ps
module servo_input_chk #(
  parameter LATCH_CYC = 20
) (
  input wire        clk_i, rstn_i, rd_i, forced_alarm_i, alarm_clear_input_i,
  input wire        positive_travel_inhibit_i, negative_travel_inhibit_i, near_home_i,
  input wire        latch_input_one_i, alarm_o, inhibit_pos_o, inhibit_neg_o,
  input wire        home_sensor_o, probe_one_o,
  input wire [31:0] rdata_o
);
  // ==========================================
  // sequences and properties
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  // no alarm source pin active
  wire quiet = !forced_alarm_i && !positive_travel_inhibit_i && !negative_travel_inhibit_i;
  sequence s_fhold;
    $rose(forced_alarm_i) ##1 (forced_alarm_i && !alarm_clear_input_i)[*8]
      ##1 (forced_alarm_i && !alarm_clear_input_i)[*8];
  endsequence
  sequence s_chold;
    $rose(alarm_clear_input_i) ##1 (alarm_clear_input_i && quiet)[*8]
      ##1 (alarm_clear_input_i && quiet)[*8];
  endsequence
  property p_forced; s_fhold |-> ##[0:4] alarm_o; endproperty
  a_forced: assert property (p_forced) else $error("forced pin gave no alarm");
  property p_clear; s_chold |-> ##[0:4] !alarm_o; endproperty
  a_clear: assert property (p_clear) else $error("alarm not cleared");
  property p_ipos; $rose(inhibit_pos_o) |-> $past(positive_travel_inhibit_i, 10); endproperty
  a_ipos: assert property (p_ipos) else $error("positive inhibit without pin");
  property p_ineg; $rose(inhibit_neg_o) |-> $past(negative_travel_inhibit_i, 10); endproperty
  a_ineg: assert property (p_ineg) else $error("negative inhibit without pin");
  property p_home; $rose(home_sensor_o) |-> $past(near_home_i, 10); endproperty
  a_home: assert property (p_home) else $error("home without sensor");
  property p_probe; probe_one_o |-> $past(latch_input_one_i, LATCH_CYC) ##1 !probe_one_o; endproperty
  a_probe: assert property (p_probe) else $error("bad probe pulse");
  property p_rd; !rd_i |=> rdata_o == 32'h0; endproperty
  a_rd: assert property (p_rd) else $error("read data without read");
  property p_cause;
    $rose(alarm_o) |-> $past(forced_alarm_i, 4) || $past(positive_travel_inhibit_i, 4)
      || $past(negative_travel_inhibit_i, 4);
  endproperty
  a_cause: assert property (p_cause) else $error("alarm from short pulse");
endmodule
bind servo_input_handler servo_input_chk #(.LATCH_CYC(LATCH_CYC)) u_chk (.*);

// ===== tb/switch_panel.sv
// model of the switches and sensors at the connector
`timescale 1ns/1ps
module switch_panel (
  input  wire        clk_i,
  output logic [6:0] pin_o,
  output logic [4:0] mon_o
);
  // open contacts read low through the pull-downs
  initial begin
    pin_o = 7'h00;
    mon_o = 5'h00;
  end
  // close one contact for n cycles, high is closed
  task automatic hold(input int i, input int n);
    @(posedge clk_i);
    pin_o[i] <= 1'b1;
    repeat (n) @(posedge clk_i);
    pin_o[i] <= 1'b0;
  endtask
  // set one contact to a level
  task automatic level(input int i, input logic b);
    @(posedge clk_i);
    pin_o[i] <= b;
  endtask
endmodule

// ===== tb/servo_input_handler_tb.sv
// self-checking bench of the input handler
`timescale 1ns/1ps
`include "servo_input_regs.vh"
module servo_input_handler_tb;
  localparam int LC = 20;
  logic        clk_i = 1'b0;
  logic        rstn_i = 1'b0;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic [7:0]  addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic [31:0] v;
  logic [15:0] fbt = 16'h0777;
  logic [15:0] fbs = 16'h0321;
  wire  [6:0]  pin;
  wire  [4:0]  mon;
  wire  [31:0] rdata;
  wire  [15:0] tq, sl;
  wire         irq, alm, ipos, ineg, istop, home, p1, p2;
  int          n_errors = 0;
  int          checks = 0;
  int          cyc = 0;
  int          np1 = 0;
  int          np2 = 0;
  typedef struct { logic [7:0] a; logic w; logic [31:0] d, e; } row_t;
  // address, write flag, write data, expected read
  row_t rows[9] = '{'{8'h00, 0, 0, 0}, '{8'h24, 0, 0, 32'h65}, '{8'h14, 0, 0, 32'hbb8},
    '{8'h10, 0, 0, 0}, '{8'h08, 0, 0, 0}, '{8'h14, 1, 32'h1234, 32'h1234},
    '{8'h18, 1, 32'habcd, 32'habcd}, '{8'h04, 1, 32'hffff, 0}, '{8'h30, 1, 32'h5, 0}};
  switch_panel sw (.clk_i(clk_i), .pin_o(pin), .mon_o(mon));
  servo_input_handler #(.LATCH_CYC(LC)) uut (
    .clk_i(clk_i), .rstn_i(rstn_i), .forced_alarm_i(pin[0]),
    .positive_travel_inhibit_i(pin[1]), .negative_travel_inhibit_i(pin[2]),
    .near_home_i(pin[3]), .latch_input_one_i(pin[4]), .latch_input_two_i(pin[5]),
    .general_monitor_input_i(mon), .alarm_clear_input_i(pin[6]), .fieldbus_torque_i(fbt),
    .fieldbus_speed_limit_i(fbs), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata), .irq_o(irq), .alarm_o(alm), .inhibit_pos_o(ipos),
    .inhibit_neg_o(ineg), .inhibit_stop_o(istop), .home_sensor_o(home),
    .probe_one_o(p1), .probe_two_o(p2), .torque_cmd_o(tq), .speed_limit_o(sl));
  // clock
  always #5 clk_i = ~clk_i;
  // probe pulse counters and hang limit
  always @(posedge clk_i) begin
    np1 <= np1 + p1;
    np2 <= np2 + p2;
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_errors++;
      wrap_up();
    end
  end
  task automatic cmp(input string s, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic wrap_up();
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (16) @(posedge clk_i);
    rstn_i <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].w) wr(rows[i].a, rows[i].d);
      rd(rows[i].a);
      cmp("register", rows[i].e, v);
    end
    cmp("torque reg", 32'habcd, tq);
    wr(`REG_CTRL, 32'h18);
    wt(3);
    cmp("torque", fbt, tq);
    cmp("speed", fbs, sl);
    wr(`REG_CTRL, 32'h0);
    wr(`REG_IRQ_MASK, 32'h1f);
    sw.hold(0, 20);
    wt(4);
    cmp("alarm", 1, alm);
    cmp("irq", 1, irq);
    rd(`REG_ALARM);
    cmp("code", `ALARM_FORCED, v);
    wr(`REG_HIST_INDEX, 32'h0);
    rd(`REG_HIST_DATA);
    cmp("history", `ALARM_FORCED, v);
    sw.hold(6, 20);
    wt(4);
    cmp("cleared", 0, alm);
    wr(`REG_IRQ_STATUS, 32'h1f);
    wt(3);
    cmp("irq off", 0, irq);
    sw.hold(0, 5);
    wt(20);
    cmp("glitch", 0, alm);
    sw.level(1, 1);
    sw.level(2, 1);
    wt(16);
    cmp("pos", 1, ipos);
    cmp("neg", 1, ineg);
    sw.level(1, 0);
    sw.level(2, 0);
    // let the filtered inhibits fall so the next rise is seen
    wt(16);
    wr(`REG_CTRL, 32'h2);
    sw.level(2, 1);
    wt(16);
    cmp("stop", 1, istop);
    rd(`REG_ALARM);
    cmp("ot code", `ALARM_OT, v);
    sw.level(2, 0);
    sw.hold(6, 20);
    wr(`REG_CTRL, 32'h1);
    sw.level(1, 1);
    wt(16);
    cmp("ot off", 0, ipos | istop | alm);
    sw.level(1, 0);
    wr(`REG_CTRL, 32'h4);
    sw.level(3, 1);
    wt(16);
    cmp("home", 1, home);
    wr(`REG_CTRL, 32'h0);
    wt(3);
    cmp("home off", 0, home);
    sw.level(3, 0);
    sw.hold(4, LC + 20);
    sw.hold(5, LC + 20);
    sw.hold(4, LC / 2);
    wt(20);
    cmp("probe one", 1, np1);
    cmp("probe two", 1, np2);
    wr(`REG_ALLOC, 32'h56);
    sw.hold(4, LC + 20);
    sw.hold(5, LC + 20);
    wt(20);
    cmp("slots", 2, np1 + np2);
    sw.mon_o <= 5'h15;
    wt(16);
    rd(`REG_DIGIN);
    cmp("monitor", 32'h540, v);
    cmp("no effect", 0, alm | ipos | ineg | home);
    // reset in mid-run brings outputs and slots back
    @(posedge clk_i);
    rstn_i <= 1'b0;
    wt(2);
    cmp("reset outs", 0, {alm, ipos, ineg, istop, home, irq, p1, p2});
    @(posedge clk_i);
    rstn_i <= 1'b1;
    rd(`REG_ALLOC);
    cmp("alloc reset", 32'h65, v);
    wrap_up();
  end
endmodule
